// ==== serial_flash_program_erase_power.sv ====
// Purpose: Program, erase and deep power-down sequencing of a serial paged
//   flash, with the link shifter on its own serial clock.
// Assumes: Host keeps chip select high for several system clocks between
//   frames; serial clock stands still while chip select is high.
// Notes: The array is kept here so that its contents can be read back.
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_map.svh"

module serial_flash_program_erase_power
  import flash_seq_pkg::*;
#(
  parameter int MEM_BYTES = `MEM_BYTES_DEF,
  parameter int SECTOR_BYTES = `SECTOR_BYTES_DEF,
  parameter logic [7:0] PROGRAM_CMD = `PAGE_PROGRAM_CODE,
  parameter logic [7:0] PAGE_CLR_CMD = `PAGE_ERASE_CODE,
  parameter logic [7:0] BLOCK_CLR_CMD = `BLOCK_CLEAR_CODE,
  parameter logic [7:0] SLEEP_CMD = `DEEP_SLEEP_CODE,
  parameter logic [7:0] WAKE_CMD = `WAKE_CODE,
  parameter logic [7:0] UNLOCK_CMD = `WRITE_UNLOCK_CODE,
  parameter int PROG_TIME_NS = `PROG_TIME_NS,
  parameter int PAGE_CLR_TIME_NS = `PAGE_CLR_TIME_NS,
  parameter int BLOCK_CLR_TIME_NS = `BLOCK_CLR_TIME_NS,
  parameter int SLEEP_ENTRY_TIME_NS = `SLEEP_ENTRY_TIME_NS,
  parameter int WAKE_TIME_NS = `WAKE_TIME_NS,
  localparam int AW = $clog2(MEM_BYTES),
  localparam int PAGES = MEM_BYTES / `PAGE_BYTES
)(
  // System clock, reset and freeze.
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Serial link pins.
  input wire logic spi_sck,
  input wire logic cs_n,
  input wire logic sdi,
  // Hardware page protection, one bit per page.
  input wire logic [PAGES-1:0] page_lock,
  // Array read-back port.
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data,
  // Status.
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic deep_sleep
);

  localparam int PROG_CYC = (PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int PCLR_CYC =
    (PAGE_CLR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int BCLR_CYC =
    (BLOCK_CLR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SLEEP_CYC =
    (SLEEP_ENTRY_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WAKE_CYC = (WAKE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

  // Geometry that the walk and protection logic depend on.
  if (MEM_BYTES < 2 * `PAGE_BYTES || SECTOR_BYTES < `PAGE_BYTES ||
      MEM_BYTES % SECTOR_BYTES != 0 || SECTOR_BYTES % `PAGE_BYTES != 0 ||
      (1 << AW) != MEM_BYTES || AW > 24) begin : g_bad_geometry
    $error("Array and sector sizes must be powers of two, page multiples.");
  end

  // Link domain: shifter and byte hand-off, on the serial clock.
  logic armed_reg;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] byte_reg, byte_next;
  logic tgl_reg, tgl_next;
  logic mid_reg, mid_next;

  // A frame's first edge is recognised by the flag chip select presets.
  always_ff @(posedge spi_sck or posedge cs_n) begin
    if (cs_n) begin
      armed_reg <= 1'b1;
    end else begin
      armed_reg <= 1'b0;
    end
  end

  always_comb begin
    bit_cnt_next = armed_reg ? 3'h1 : bit_cnt_reg + 3'h1;
    shift_next = {shift_reg[6:0], sdi};
    byte_next = byte_reg;
    tgl_next = tgl_reg;
    if (bit_cnt_next == 3'h0) begin
      byte_next = shift_next;
      tgl_next = ~tgl_reg;
    end
    mid_next = (bit_cnt_next != 3'h0);
  end

  // Counters survive chip select rising so the end state can be judged.
  always_ff @(posedge spi_sck or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_reg <= 8'h00;
      tgl_reg <= 1'b0;
      mid_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_reg <= byte_next;
      tgl_reg <= tgl_next;
      mid_reg <= mid_next;
    end
  end

  // Crossing: three stages, a change counts when stages two and three agree.
  link_levels_t s1_reg, s2_reg, s3_reg, filt_reg, filt_prev_reg;
  link_levels_t raw_lvl, filt_next;

  always_comb begin
    raw_lvl = '{cs_n: cs_n, byte_tgl: tgl_reg, mid_byte: mid_reg};
    filt_next = filt_reg;
    for (int i = 0; i < 3; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        filt_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_reg <= '{cs_n: 1'b1, byte_tgl: 1'b0, mid_byte: 1'b0};
      s2_reg <= '{cs_n: 1'b1, byte_tgl: 1'b0, mid_byte: 1'b0};
      s3_reg <= '{cs_n: 1'b1, byte_tgl: 1'b0, mid_byte: 1'b0};
      filt_reg <= '{cs_n: 1'b1, byte_tgl: 1'b0, mid_byte: 1'b0};
      filt_prev_reg <= '{cs_n: 1'b1, byte_tgl: 1'b0, mid_byte: 1'b0};
    end else if (clk_en) begin
      s1_reg <= raw_lvl;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  // Events seen by the system domain. The byte itself is quasi-static: it
  // holds for a whole byte time after its toggle, so no word sync is needed.
  logic rx_byte, frame_start, frame_end;
  assign rx_byte = filt_reg.byte_tgl != filt_prev_reg.byte_tgl;
  assign frame_start = !filt_reg.cs_n && filt_prev_reg.cs_n;
  assign frame_end = filt_reg.cs_n && !filt_prev_reg.cs_n;

  // System domain state.
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [`PAGE_BYTES];
  dev_state_t state_reg, state_next;
  cycle_op_t op_reg, op_next;
  logic [2:0] nbytes_reg, nbytes_next;
  logic [7:0] opcode_reg, opcode_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0] dcnt_reg, dcnt_next;
  logic [`PAGE_BYTES-1:0] mask_reg, mask_next;
  logic eval_reg, eval_next;
  logic unlock_reg, unlock_next;
  logic [31:0] timer_reg, timer_next;
  logic [AW:0] walk_reg, walk_next, walk_len_reg, walk_len_next;
  logic [AW-1:0] base_reg, base_next;
  logic [7:0] rd_data_reg;
  logic buf_we, mem_we;
  logic [7:0] buf_wa, mem_wd, mem_old;
  logic [AW-1:0] mem_wa, cur_addr, page_base, sect_base;
  logic aligned, pg_locked, sc_locked;

  function automatic logic sector_locked(input logic [AW-1:0] a,
                                         input logic [PAGES-1:0] lk);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < PAGES; p++) begin
      if (lk[p] && (p * `PAGE_BYTES) / SECTOR_BYTES == int'(a) / SECTOR_BYTES)
      begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign cur_addr = addr_reg[AW-1:0];
  assign page_base = {cur_addr[AW-1:8], 8'h00};
  assign sect_base = cur_addr & ~AW'(SECTOR_BYTES - 1);
  assign pg_locked = page_lock[cur_addr[AW-1:8]];
  assign sc_locked = sector_locked(cur_addr, page_lock);
  assign aligned = !filt_reg.mid_byte;
  assign mem_wa = base_reg + walk_reg[AW-1:0];
  assign mem_old = mem[mem_wa];

  // Frame capture: opcode, address, data into the page buffer.
  always_comb begin
    nbytes_next = nbytes_reg;
    opcode_next = opcode_reg;
    addr_next = addr_reg;
    dcnt_next = dcnt_reg;
    mask_next = mask_reg;
    buf_we = 1'b0;
    buf_wa = addr_reg[7:0] + dcnt_reg;
    if (frame_start) begin
      nbytes_next = 3'h0;
      dcnt_next = 8'h00;
      // The buffer is left alone while a program walk still reads it.
      if (state_reg == PM_STANDBY) begin
        mask_next = '0;
      end
    end else if (rx_byte) begin
      if (nbytes_reg == 3'h0) begin
        opcode_next = byte_reg;
      end else if (nbytes_reg < 3'h4) begin
        addr_next = {addr_reg[15:0], byte_reg};
      end else if (opcode_reg == PROGRAM_CMD && state_reg == PM_STANDBY) begin
        buf_we = 1'b1;
        mask_next[buf_wa] = 1'b1;
        dcnt_next = dcnt_reg + 8'h01;
      end
      if (nbytes_reg != 3'h5) begin
        nbytes_next = nbytes_reg + 3'h1;
      end
    end
  end

  // Command evaluation and timed cycles.
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    unlock_next = unlock_reg;
    timer_next = timer_reg;
    walk_next = walk_reg;
    walk_len_next = walk_len_reg;
    base_next = base_reg;
    eval_next = frame_end;
    mem_we = 1'b0;
    mem_wd = `ERASED_BYTE;
    case (state_reg)
      PM_STANDBY: begin
        if (eval_reg && aligned) begin
          if (opcode_reg == UNLOCK_CMD && nbytes_reg == 3'h1) begin
            unlock_next = 1'b1;
          end else if (opcode_reg == PROGRAM_CMD && nbytes_reg == 3'h5 &&
                       unlock_reg && !pg_locked) begin
            state_next = PM_BUSY;
            op_next = OP_PROGRAM;
            timer_next = 32'(PROG_CYC - 1);
            base_next = page_base;
            walk_len_next = (AW + 1)'(`PAGE_BYTES);
          end else if (opcode_reg == PAGE_CLR_CMD && nbytes_reg == 3'h4 &&
                       unlock_reg && !pg_locked) begin
            state_next = PM_BUSY;
            op_next = OP_PAGE_CLEAR;
            timer_next = 32'(PCLR_CYC - 1);
            base_next = page_base;
            walk_len_next = (AW + 1)'(`PAGE_BYTES);
          end else if (opcode_reg == BLOCK_CLR_CMD && nbytes_reg == 3'h4 &&
                       unlock_reg && !sc_locked) begin
            state_next = PM_BUSY;
            op_next = OP_BLOCK_CLEAR;
            timer_next = 32'(BCLR_CYC - 1);
            base_next = sect_base;
            walk_len_next = (AW + 1)'(SECTOR_BYTES);
          end else if (opcode_reg == SLEEP_CMD && nbytes_reg == 3'h1) begin
            state_next = PM_SLEEP_ENTRY;
            timer_next = 32'(SLEEP_CYC - 1);
          end
          // Latch clears as the cycle starts
          if (state_next == PM_BUSY) begin
            unlock_next = 1'b0;
            walk_next = '0;
          end
        end
      end
      PM_BUSY: begin
        if (walk_reg != walk_len_reg) begin
          mem_we = 1'b1;
          walk_next = walk_reg + 1'b1;
          if (op_reg == OP_PROGRAM) begin
            mem_wd = mask_reg[walk_reg[7:0]] ?
                     (mem_old & pbuf[walk_reg[7:0]]) : mem_old;
          end
        end
        if (timer_reg != 32'h0) begin
          timer_next = timer_reg - 32'h1;
        end else if (walk_reg == walk_len_reg) begin
          state_next = PM_STANDBY;
        end
      end
      PM_SLEEP_ENTRY: begin
        if (timer_reg != 32'h0) begin
          timer_next = timer_reg - 32'h1;
        end else begin
          state_next = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        if (eval_reg && aligned && opcode_reg == WAKE_CMD &&
            nbytes_reg == 3'h1) begin
          state_next = PM_WAKE;
          timer_next = 32'(WAKE_CYC - 1);
        end
      end
      PM_WAKE: begin
        if (timer_reg != 32'h0) begin
          timer_next = timer_reg - 32'h1;
        end else begin
          state_next = PM_STANDBY;
        end
      end
      default: begin
        state_next = PM_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= PM_STANDBY;
      op_reg <= OP_PROGRAM;
      nbytes_reg <= 3'h0;
      opcode_reg <= 8'h00;
      addr_reg <= 24'h000000;
      dcnt_reg <= 8'h00;
      mask_reg <= '0;
      eval_reg <= 1'b0;
      unlock_reg <= 1'b0;
      timer_reg <= 32'h0;
      walk_reg <= '0;
      walk_len_reg <= '0;
      base_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
      op_reg <= op_next;
      nbytes_reg <= nbytes_next;
      opcode_reg <= opcode_next;
      addr_reg <= addr_next;
      dcnt_reg <= dcnt_next;
      mask_reg <= mask_next;
      eval_reg <= eval_next;
      unlock_reg <= unlock_next;
      timer_reg <= timer_next;
      walk_reg <= walk_next;
      walk_len_reg <= walk_len_next;
      base_reg <= base_next;
    end
  end

  // Storage has no reset: the array keeps its contents like real cells.
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (buf_we) begin
        pbuf[buf_wa] <= byte_reg;
      end
      if (mem_we) begin
        mem[mem_wa] <= mem_wd;
      end
      rd_data_reg <= mem[rd_addr];
    end
  end

  assign rd_data = rd_data_reg;
  assign busy_flag = state_reg == PM_BUSY;
  assign write_unlock_latch = unlock_reg;
  assign deep_sleep = state_reg == PM_SLEEP || state_reg == PM_WAKE;

endmodule

`default_nettype wire

// ==== serial_flash_map.svh ====
// Purpose: Offsets, sizes, command codes and timing figures of the flash
//   program, erase and power sequencer.
// Assumes: A 50 ns system clock; times are given in nanoseconds.
// Notes: Definitions only.
`ifndef SERIAL_FLASH_MAP_SVH
`define SERIAL_FLASH_MAP_SVH

// Clock period of the system domain.
`define CLK_PERIOD_NS 50

// Array geometry: whole array, one page, one sector.
`define MEM_BYTES_DEF 131072
`define PAGE_BYTES 256
`define SECTOR_BYTES_DEF 65536

// Command codes (defaults, overridable per instance).
`define PAGE_PROGRAM_CODE 8'h02
`define PAGE_ERASE_CODE 8'hDB
`define BLOCK_CLEAR_CODE 8'hD8
`define DEEP_SLEEP_CODE 8'hB9
`define WAKE_CODE 8'hAB
`define WRITE_UNLOCK_CODE 8'h06

// Self-timed durations and power-mode delays, in nanoseconds.
`define PROG_TIME_NS 20000
`define PAGE_CLR_TIME_NS 40000
`define BLOCK_CLR_TIME_NS 100000
`define SLEEP_ENTRY_TIME_NS 3000
`define WAKE_TIME_NS 30000

// Erased byte value.
`define ERASED_BYTE 8'hFF

`endif

// ==== flash_seq_pkg.sv ====
// Purpose: Types shared by the flash program, erase and power sequencer.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes: States are one-hot with codes written out.
`default_nettype none
package flash_seq_pkg;

  // Power and activity states of the device.
  typedef enum logic [4:0] {
    PM_STANDBY = 5'h01,
    PM_BUSY = 5'h02,
    PM_SLEEP_ENTRY = 5'h04,
    PM_SLEEP = 5'h08,
    PM_WAKE = 5'h10
  } dev_state_t;

  // Kind of self-timed cycle in progress.
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_PAGE_CLEAR = 2'h1,
    OP_BLOCK_CLEAR = 2'h2
  } cycle_op_t;

  // Levels handed from the link domain to the system domain.
  typedef struct packed {
    logic cs_n;
    logic byte_tgl;
    logic mid_byte;
  } link_levels_t;

endpackage
`default_nettype wire

// ==== flash_seq_monitor.sv ====
// Purpose: Port checks of the flash program, erase and power sequencer.
// Assumes: clk_en held high; figures in 50 ns clocks.
// Notes: Bound to every sequencer instance.
`timescale 1ns/10ps
`default_nettype none
module flash_seq_monitor #(
  parameter int MEM_BYTES = 131072,
  parameter int PROG_CLKS = 400,
  parameter int WAKE_CLKS = 600,
  parameter int MAX_BUSY = 2001
)(
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // Link pins.
  input wire logic spi_sck,
  input wire logic cs_n,
  input wire logic sdi,
  // Array side.
  input wire logic [MEM_BYTES/256-1:0] page_lock,
  input wire logic [$clog2(MEM_BYTES)-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Status.
  input wire logic busy_flag,
  input wire logic write_unlock_latch,
  input wire logic deep_sleep
);
  logic [15:0] busy_cnt_reg, busy_cnt_next, idle_cnt_reg, idle_cnt_next;

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Run lengths; the busy count stays far below the width since cycles are bounded.
  always_comb begin
    busy_cnt_next = busy_flag ? busy_cnt_reg + 16'h0001 : 16'h0000;
    // Chip select high run, held at its top so a long idle cannot wrap.
    idle_cnt_next = !cs_n ? 16'h0000 :
      (idle_cnt_reg == 16'hFFFF) ? idle_cnt_reg : idle_cnt_reg + 16'h0001;
  end

  // Counter registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      busy_cnt_reg <= 16'h0000;
      idle_cnt_reg <= 16'h0000;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  a_reset_standby: assert property ($fell(sys_rst) |->
    !busy_flag && !write_unlock_latch && !deep_sleep)
    else $error("status not clear after reset");
  a_busy_needs_latch: assert property ($rose(busy_flag) |->
    $past(write_unlock_latch) || $past(write_unlock_latch, 2))
    else $error("cycle started without unlock latch");
  a_latch_clears_start: assert property ($rose(busy_flag) |->
    !write_unlock_latch) else $error("latch still set at cycle start");
  a_busy_on_deselect: assert property ($rose(busy_flag) |->
    cs_n && $past(cs_n, 3)) else $error("cycle started while selected");
  a_latch_on_deselect: assert property ($rose(write_unlock_latch) |->
    cs_n && $past(cs_n, 3)) else $error("latch set while selected");
  a_busy_min_len: assert property ($fell(busy_flag) |->
    busy_cnt_reg >= PROG_CLKS) else $error("busy ended too soon");
  a_busy_max_len: assert property (busy_cnt_reg <= MAX_BUSY)
    else $error("busy lasted too long");
  a_sleep_not_busy: assert property (deep_sleep |-> !busy_flag)
    else $error("busy while in deep sleep");
  a_sleep_no_unlock: assert property (deep_sleep |->
    !$rose(write_unlock_latch)) else $error("unlock heard in deep sleep");
  a_sleep_after_idle: assert property ($rose(deep_sleep) |->
    !$past(busy_flag, 61)) else $error("sleep accepted while busy");
  a_wake_recovery: assert property ($fell(deep_sleep) |->
    idle_cnt_reg >= WAKE_CLKS) else $error("wake recovery too short");

  c_cycle: cover property ($rose(busy_flag));
  c_sleep: cover property ($rose(deep_sleep));
  c_wake: cover property ($fell(deep_sleep));
endmodule

bind serial_flash_program_erase_power flash_seq_monitor #(
  .MEM_BYTES(MEM_BYTES)) i_mon (.clock(clock), .sys_rst(sys_rst),
  .clk_en(clk_en), .spi_sck(spi_sck), .cs_n(cs_n), .sdi(sdi),
  .page_lock(page_lock), .rd_addr(rd_addr), .rd_data(rd_data),
  .busy_flag(busy_flag), .write_unlock_latch(write_unlock_latch),
  .deep_sleep(deep_sleep));
`default_nettype wire

// ==== spi_host_model.sv ====
// Purpose: Behavioural host framing commands on the serial link.
// Assumes: Serial clock idles low and runs only inside frames.
// Notes: Callers fill fb and call send; bit period is 125 ns.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Serial link pins.
  output var logic cs_n,
  output var logic spi_sck,
  output var logic sdi
);
  logic [7:0] fb [0:263];

  // Idle link: deselected, clock parked low. Chip select rises just after
  // time zero so the frame flag in the block sees a real edge.
  initial begin
    cs_n = 1'b0;
    spi_sck = 1'b0;
    sdi = 1'b1;
    #1;
    cs_n = 1'b1;
  end

  // One frame of nb bytes plus extra loose bits, MSB first.
  task automatic send(input int nb, input int extra);
    int i;
    #13;
    cs_n = 1'b0;
    for (i = 0; i < nb * 8 + extra; i++) begin
      sdi = fb[i / 8][7 - i % 8];
      #62.5;
      spi_sck = 1'b1;
      #62.5;
      spi_sck = 1'b0;
    end
    #62.5;
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Purpose: Self-checking bench for the flash program, erase and power block.
// Assumes: Small array (1 KiB, 512-byte sectors) keeps sector walks short.
// Notes: Array has no reset, so the first act is a sector erase.
`timescale 1ns/10ps
`default_nettype none
`include "serial_flash_map.svh"
module testbench import flash_seq_pkg::*;;
  logic clock = 1'b0;
  logic sys_rst = 1'b0;
  logic clk_en = 1'b1;
  logic [3:0] page_lock = 4'h0;
  logic [9:0] rd_addr = 10'h000;
  logic cs_n, spi_sck, sdi, busy_flag, write_unlock_latch, deep_sleep;
  logic [7:0] rd_data;
  int n_fail = 0;
  int total_checks = 0;

  // System clock at 50 ns.
  always #25 clock = ~clock;

  serial_flash_program_erase_power #(.MEM_BYTES(1024), .SECTOR_BYTES(512))
    i_dut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .spi_sck(spi_sck), .cs_n(cs_n), .sdi(sdi), .page_lock(page_lock),
    .rd_addr(rd_addr), .rd_data(rd_data), .busy_flag(busy_flag),
    .write_unlock_latch(write_unlock_latch), .deep_sleep(deep_sleep));
  spi_host_model i_host (.cs_n(cs_n), .spi_sck(spi_sck), .sdi(sdi));

  // Verdict and end of run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Compare and count.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Read back one array byte; data is registered one clock late.
  task automatic rd_chk(input int a, input logic [7:0] exp);
    @(negedge clock);
    rd_addr = a[9:0];
    @(negedge clock);
    @(negedge clock);
    check(rd_data, exp);
  endtask

  // Frame: opcode, address, data d with the last two bytes d2.
  task automatic issue(input logic [7:0] op, input logic [23:0] a,
      input int nb, input logic [7:0] d, input logic [7:0] d2,
      input int extra);
    int i;
    i_host.fb[0] = op;
    i_host.fb[1] = a[23:16];
    i_host.fb[2] = a[15:8];
    i_host.fb[3] = a[7:0];
    for (i = 4; i < 264; i++) begin
      i_host.fb[i] = (i >= nb - 2) ? d2 : d;
    end
    i_host.send(nb, extra);
    repeat (12) @(negedge clock);
  endtask

  // Unlock frame.
  task automatic unlock();
    issue(`WRITE_UNLOCK_CODE, 24'h000000, 1, 8'h00, 8'h00, 0);
  endtask

  // Bounded wait for the end of a timed cycle.
  task automatic settle();
    int i;
    for (i = 0; i < 3000 && busy_flag === 1'b1; i++) begin
      @(negedge clock);
    end
    if (busy_flag !== 1'b0) begin
      n_fail++;
      summarize();
    end
  endtask

  // Bounded wait for a deep sleep level.
  task automatic wait_sleep(input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && deep_sleep !== lvl; i++) begin
      @(negedge clock);
    end
    if (deep_sleep !== lvl) begin
      n_fail++;
      summarize();
    end
  endtask

  // Main sequence.
  initial begin
    // Reset rises after time zero so the link flops see a real edge.
    #1;
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    check({5'h00, busy_flag, write_unlock_latch, deep_sleep}, 8'h00);
    unlock();
    check({7'h00, write_unlock_latch}, 8'h01);
    issue(`BLOCK_CLEAR_CODE, 24'h000000, 4, 8'h00, 8'h00, 0);
    check({6'h00, busy_flag, write_unlock_latch}, 8'h02);
    settle();
    rd_chk(0, 8'hFF);
    rd_chk(511, 8'hFF);
    issue(`PAGE_PROGRAM_CODE, 24'h000000, 5, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h00);
    rd_chk(0, 8'hFF);
    unlock();
    issue(`PAGE_PROGRAM_CODE, 24'h0000FE, 7, 8'hC3, 8'h5A, 0);
    settle();
    rd_chk(254, 8'hC3);
    rd_chk(0, 8'h5A);
    rd_chk(1, 8'hFF);
    unlock();
    issue(`PAGE_PROGRAM_CODE, 24'h0000FE, 5, 8'h00, 8'h3C, 0);
    settle();
    rd_chk(254, 8'h00);
    rd_chk(255, 8'h5A);
    unlock();
    issue(`PAGE_PROGRAM_CODE, 24'h000100, 262, 8'h11, 8'h22, 0);
    settle();
    rd_chk(256, 8'h22);
    rd_chk(257, 8'h22);
    rd_chk(258, 8'h11);
    unlock();
    issue(`PAGE_PROGRAM_CODE, 24'h000000, 5, 8'h00, 8'h00, 3);
    check({7'h00, busy_flag}, 8'h00);
    rd_chk(0, 8'h5A);
    unlock();
    issue(`PAGE_ERASE_CODE, 24'h000010, 5, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h00);
    @(negedge clock);
    page_lock = 4'h1;
    unlock();
    issue(`PAGE_ERASE_CODE, 24'h000010, 4, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h00);
    @(negedge clock);
    page_lock = 4'h2;
    unlock();
    issue(`BLOCK_CLEAR_CODE, 24'h000040, 4, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h00);
    rd_chk(0, 8'h5A);
    @(negedge clock);
    page_lock = 4'h0;
    unlock();
    issue(`PAGE_ERASE_CODE, 24'h000180, 4, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h01);
    issue(`DEEP_SLEEP_CODE, 24'h000000, 1, 8'h00, 8'h00, 0);
    issue(`PAGE_PROGRAM_CODE, 24'h000000, 5, 8'h00, 8'h00, 0);
    check({7'h00, busy_flag}, 8'h01);
    settle();
    repeat (100) @(negedge clock);
    check({7'h00, deep_sleep}, 8'h00);
    rd_chk(256, 8'hFF);
    rd_chk(0, 8'h5A);
    unlock();
    issue(`BLOCK_CLEAR_CODE, 24'hFE0040, 4, 8'h00, 8'h00, 0);
    settle();
    rd_chk(0, 8'hFF);
    rd_chk(254, 8'hFF);
    issue(`DEEP_SLEEP_CODE, 24'h000000, 1, 8'h00, 8'h00, 0);
    wait_sleep(1'b1, 200);
    check({7'h00, deep_sleep}, 8'h01);
    unlock();
    check({7'h00, write_unlock_latch}, 8'h00);
    issue(`WAKE_CODE, 24'h000000, 1, 8'h00, 8'h00, 1);
    repeat (700) @(negedge clock);
    check({7'h00, deep_sleep}, 8'h01);
    issue(`WAKE_CODE, 24'h000000, 1, 8'h00, 8'h00, 0);
    wait_sleep(1'b0, 800);
    check({7'h00, deep_sleep}, 8'h00);
    unlock();
    check({7'h00, write_unlock_latch}, 8'h01);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    check({5'h00, busy_flag, write_unlock_latch, deep_sleep}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
